// ### design/mkx_core.sv
// Meter key revision and expiry store, token expiry check and the
// account and control digit block builders, behind an AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset, software-driven tokens.
//
// Overview of operation
// - Revision is one digit, one to nine.
// - Store revision from accepted key change set.
// - Initial transfer key carries no revision.
// - Expiry rebuilt from high and low fields.
// - Eight-bit expiry compared with identifier top byte.
// - Optionally reject identifiers above stored expiry.
// - Key change sets skip the expiry check.
// - Initial transfer key carries no expiry.
// - Account block sixteen digits, low issuer digits then reference.
// - Eleven-digit reference: five issuer digits above.
// - Thirteen-digit reference: three issuer digits above.
// - Short issuer right justified, zero filled left.
// - Common key type zeroes all reference digits.
// - Account digits are decimal, zero to nine.
// - Control block: type, group, tariff, revision, pad.
// - Pad digits F, type zero-three, revision one-nine.
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "mkx_regs.svh"

module mkx_core
  import mkx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             token_reject,
  output logic [3:0]       key_revision_number,
  output logic [7:0]       key_expiry_number
);

  // ==========================================
  // State and derived terms
  mkx_state_t  st_ff;      // Registered state
  mkx_state_t  nxt_st;     // Next state
  logic [63:0] acct_blk;   // Account digit block
  logic [63:0] ctrl_blk;   // Control digit block
  logic        acct_bad;   // Some account digit above nine
  logic        ctrl_bad;   // Some control digit out of range
  logic        wr_go;      // Held write performed this cycle
  logic [31:0] wr_val;     // Write data merged by byte enables
  logic [31:0] cur_val;    // Current value of the addressed word
  logic        wr_map;     // Write address is mapped
  logic        kct_ok;     // Pending key change fields are legal
  logic [7:0]  kct_exp;    // Expiry rebuilt from the two fields
  mkx_ktype_t  kct_type;   // Pending key type
  logic [23:0] tok_id;     // Identifier being written
  logic [15:0] acct_dbad;  // Per-digit range flags
  logic [15:0] ctrl_dbad;

  assign kct_type = mkx_ktype_t'(st_ff.kct[13:12]);
  assign kct_exp  = {st_ff.kct[7:4], st_ff.kct[11:8]};
  // Initial type needs no revision; others need one to nine
  assign kct_ok   = (kct_type == MKX_KEY_INIT) ||
                   ((st_ff.kct[3:0] >= `MKX_REV_MIN) && (st_ff.kct[3:0] <= `MKX_REV_MAX));

  // ==========================================
  // Account block: issuer digits above, reference digits below
  always_comb begin
    if (st_ff.ctrl[`MKX_CTRL_MREF13]) begin
      acct_blk = {st_ff.issuer[11:0], st_ff.mref_hi[19:0], st_ff.mref_lo};
    end else begin
      acct_blk = {st_ff.issuer[19:0], st_ff.mref_hi[11:0], st_ff.mref_lo};
    end
    // Issuer register holds zero upper digits, so a short issuer pads left
    // with zeros by itself
    if (kct_type == MKX_KEY_COMMON) begin
      if (st_ff.ctrl[`MKX_CTRL_MREF13]) begin
        acct_blk[51:0] = 52'h0;
      end else begin
        acct_blk[43:0] = 44'h0;
      end
    end
  end

  // Control block built from the pending key change fields
  assign ctrl_blk = {2'h0, kct_type, st_ff.supply[23:0], st_ff.supply[31:24],
                     st_ff.kct[3:0], `MKX_PAD_DIGITS};

  // Digit range checks, one per position
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_dig
      assign acct_dbad[gi] = acct_blk[gi*4 +: 4] > `MKX_DIGIT_MAX;
      if (gi == 15) begin : g_kt
        assign ctrl_dbad[gi] = 1'b0;  // Type field is two bits, never reserved
      end else if (gi == 6) begin : g_rev
        assign ctrl_dbad[gi] = !kct_ok;
      end else if (gi < 6) begin : g_pad
        assign ctrl_dbad[gi] = 1'b0;
      end else begin : g_num
        assign ctrl_dbad[gi] = ctrl_blk[gi*4 +: 4] > `MKX_DIGIT_MAX;
      end
    end
  endgenerate
  assign acct_bad = |acct_dbad;
  assign ctrl_bad = |ctrl_dbad;

  // ==========================================
  // Write path helpers
  assign wr_go  = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
  assign wr_map = st_ff.awaddr[1:0] == 2'h0 && st_ff.awaddr <= `MKX_OFS_CBLK_HI;
  assign tok_id = wr_val[23:0];

  // Current word under the write address, for byte-lane merging
  always_comb begin
    unique case (st_ff.awaddr)
      `MKX_OFS_CTRL:   cur_val = st_ff.ctrl;
      `MKX_OFS_KCT:    cur_val = st_ff.kct;
      `MKX_OFS_TOKEN:  cur_val = {7'h0, st_ff.token};
      `MKX_OFS_ISSUER: cur_val = st_ff.issuer;
      `MKX_OFS_MREF_LO: cur_val = st_ff.mref_lo;
      `MKX_OFS_MREF_HI: cur_val = st_ff.mref_hi;
      `MKX_OFS_SUPPLY: cur_val = st_ff.supply;
      default:         cur_val = `MKX_RST_WORD;
    endcase
  end

  // Byte lanes without a strobe keep their old contents
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_val[b*8 +: 8] = st_ff.wstrb[b] ? st_ff.wdata[b*8 +: 8] : cur_val[b*8 +: 8];
    end
  end

  // ==========================================
  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    // Capture address and data in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // Perform the held write once both halves are in
    if (wr_go) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = wr_map ? `MKX_RESP_OKAY : `MKX_RESP_SLVERR;
      unique case (st_ff.awaddr)
        `MKX_OFS_CTRL:   nxt_st.ctrl   = wr_val;
        `MKX_OFS_KCT:    nxt_st.kct    = {18'h0, wr_val[13:0]};
        `MKX_OFS_ISSUER:  nxt_st.issuer  = {12'h0, wr_val[19:0]};
        `MKX_OFS_MREF_LO: nxt_st.mref_lo = wr_val;
        `MKX_OFS_MREF_HI: nxt_st.mref_hi = {12'h0, wr_val[19:0]};
        `MKX_OFS_SUPPLY: nxt_st.supply = wr_val;
        `MKX_OFS_CMD: begin
          // Commit only a legal set; a refused set keeps the old key data
          if (wr_val[`MKX_CMD_COMMIT]) begin
            nxt_st.commit_err = !kct_ok;
            if (kct_ok) begin
              nxt_st.ktype = kct_type;
              if (kct_type == MKX_KEY_INIT) begin
                nxt_st.rev = 4'h0;
                nxt_st.exp = 8'h00;
              end else begin
                nxt_st.rev = st_ff.kct[3:0];
                nxt_st.exp = kct_exp;
              end
            end
          end
        end
        `MKX_OFS_TOKEN: begin
          nxt_st.token   = wr_val[24:0];
          nxt_st.checked = 1'b1;
          // Only identifier tokens are checked, and only when expiry is on
          nxt_st.reject  = wr_val[`MKX_TOKEN_HASID] && st_ff.ctrl[`MKX_CTRL_EXP_EN] &&
                           (st_ff.ktype != MKX_KEY_INIT) && (tok_id[23:16] > st_ff.exp);
        end
        default: begin
          // Read-only or unmapped: no effect
        end
      endcase
    end
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;
    // Read channel: one read under way, answered the cycle after address
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = `MKX_RESP_OKAY;
      unique case (s_axi_araddr)
        `MKX_OFS_CTRL:    nxt_st.rdata = st_ff.ctrl;
        `MKX_OFS_KCT:     nxt_st.rdata = st_ff.kct;
        `MKX_OFS_CMD:     nxt_st.rdata = `MKX_RST_WORD;
        `MKX_OFS_TOKEN:   nxt_st.rdata = {7'h0, st_ff.token};
        `MKX_OFS_STATUS:  nxt_st.rdata = {11'h0, ctrl_bad, acct_bad, st_ff.commit_err, st_ff.checked,
                                          st_ff.reject, 2'h0, st_ff.ktype, st_ff.exp, st_ff.rev};
        `MKX_OFS_ISSUER:  nxt_st.rdata = st_ff.issuer;
        `MKX_OFS_MREF_LO: nxt_st.rdata = st_ff.mref_lo;
        `MKX_OFS_MREF_HI: nxt_st.rdata = st_ff.mref_hi;
        `MKX_OFS_SUPPLY:  nxt_st.rdata = st_ff.supply;
        `MKX_OFS_ACCT_LO: nxt_st.rdata = acct_blk[31:0];
        `MKX_OFS_ACCT_HI: nxt_st.rdata = acct_blk[63:32];
        `MKX_OFS_CBLK_LO: nxt_st.rdata = ctrl_blk[31:0];
        `MKX_OFS_CBLK_HI: nxt_st.rdata = ctrl_blk[63:32];
        default: begin
          nxt_st.rdata = `MKX_RST_WORD;
          nxt_st.rresp = `MKX_RESP_SLVERR;
        end
      endcase
    end
    nxt_st.arready = !nxt_st.rvalid;
  end

  // ==========================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff         <= '0;
      st_ff.awready <= 1'b1;
      st_ff.wready  <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.ktype   <= MKX_KEY_INIT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================
  // Outputs, all straight from the state register
  assign s_axi_awready       = st_ff.awready;
  assign s_axi_wready        = st_ff.wready;
  assign s_axi_bvalid        = st_ff.bvalid;
  assign s_axi_bresp         = st_ff.bresp;
  assign s_axi_arready       = st_ff.arready;
  assign s_axi_rvalid        = st_ff.rvalid;
  assign s_axi_rresp         = st_ff.rresp;
  assign s_axi_rdata         = st_ff.rdata;
  assign token_reject        = st_ff.reject;
  assign key_revision_number = st_ff.rev;
  assign key_expiry_number   = st_ff.exp;

  // ==========================================
  // Assertions and covers
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic tok_wr;   // Token write performed this cycle
  logic cmt_wr;   // Commit command performed this cycle
  assign tok_wr = wr_go && st_ff.awaddr == `MKX_OFS_TOKEN;
  assign cmt_wr = wr_go && st_ff.awaddr == `MKX_OFS_CMD && wr_val[`MKX_CMD_COMMIT];

  AST_REJECT_EXPIRED: assert property (
    tok_wr && wr_val[`MKX_TOKEN_HASID] && st_ff.ctrl[`MKX_CTRL_EXP_EN] && st_ff.ktype != MKX_KEY_INIT &&
    tok_id[23:16] > st_ff.exp |=> token_reject)
    else $error("Expired identifier token not rejected");
  AST_ACCEPT_VALID: assert property (
    tok_wr && tok_id[23:16] <= st_ff.exp |=> !token_reject)
    else $error("Identifier within expiry rejected");
  AST_NO_ID_NO_CHECK: assert property (
    tok_wr && !wr_val[`MKX_TOKEN_HASID] |=> !token_reject[*2])
    else $error("Token without identifier rejected");
  AST_REV_RANGE: assert property (
    st_ff.ktype != MKX_KEY_INIT |-> key_revision_number inside {[4'h1:4'h9]})
    else $error("Stored revision out of range");
  AST_INIT_BARE: assert property (
    st_ff.ktype == MKX_KEY_INIT |-> key_revision_number == 4'h0 && key_expiry_number == 8'h00)
    else $error("Initial key holds revision or expiry");
  AST_HOLD_KEYDATA: assert property (
    !cmt_wr |=> $stable(key_revision_number) && $stable(key_expiry_number))
    else $error("Key data changed without commit");
  AST_COMMIT_STORE: assert property (
    cmt_wr && kct_ok && kct_type != MKX_KEY_INIT |=>
    key_revision_number == $past(st_ff.kct[3:0]) && key_expiry_number == $past(kct_exp))
    else $error("Commit did not store revision and expiry");
  AST_COMMON_ZERO: assert property (
    kct_type == MKX_KEY_COMMON |-> acct_blk[43:0] == 44'h0)
    else $error("Common key account block holds reference digits");
  AST_ACCT_11: assert property (
    !st_ff.ctrl[`MKX_CTRL_MREF13] && kct_type != MKX_KEY_COMMON |->
    acct_blk[63:44] == st_ff.issuer[19:0] && acct_blk[43:0] == {st_ff.mref_hi[11:0], st_ff.mref_lo})
    else $error("Account block layout wrong");
  AST_CTRL_PAD: assert property (
    ctrl_blk[23:0] == `MKX_PAD_DIGITS && ctrl_blk[63:62] == 2'h0 &&
    (kct_type == MKX_KEY_INIT || ctrl_blk[27:24] inside {[4'h1:4'h9]} || ctrl_bad))
    else $error("Control block pad, type or revision digit wrong");
  AST_BRESP_TIME: assert property (
    wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("Write response late");

  COV_REJECT:  cover property (tok_wr ##1 token_reject);
  COV_COMMIT:  cover property (cmt_wr && kct_ok ##1 key_revision_number == 4'h9);
  COV_REFUSE:  cover property (cmt_wr && !kct_ok);
  COV_COMMON:  cover property (kct_type == MKX_KEY_COMMON && s_axi_rvalid);

endmodule

// ### shared/mkx_regs.svh
// Register map, field positions and reset values of the meter key block.
// Assumes inclusion by the design and the bench; definitions only.
`ifndef MKX_REGS_SVH
`define MKX_REGS_SVH
// ==========================================
// Register byte offsets
`define MKX_OFS_CTRL    8'h00
`define MKX_OFS_KCT     8'h04
`define MKX_OFS_CMD     8'h08
`define MKX_OFS_TOKEN   8'h0C
`define MKX_OFS_STATUS  8'h10
`define MKX_OFS_ISSUER  8'h14
`define MKX_OFS_MREF_LO 8'h18
`define MKX_OFS_MREF_HI 8'h1C
`define MKX_OFS_SUPPLY  8'h20
`define MKX_OFS_ACCT_LO 8'h24
`define MKX_OFS_ACCT_HI 8'h28
`define MKX_OFS_CBLK_LO 8'h2C
`define MKX_OFS_CBLK_HI 8'h30
// ==========================================
// Field positions
`define MKX_CTRL_EXP_EN 0
`define MKX_CTRL_MREF13 1
`define MKX_CMD_COMMIT  0
`define MKX_TOKEN_HASID 24
// ==========================================
// Values
`define MKX_RST_WORD    32'h0000_0000
`define MKX_REV_MIN     4'h1
`define MKX_REV_MAX     4'h9
`define MKX_DIGIT_MAX   4'h9
`define MKX_PAD_DIGITS  24'hFF_FFFF
`define MKX_RESP_OKAY   2'h0
`define MKX_RESP_SLVERR 2'h2
`endif

// ### shared/mkx_pkg.sv
// Types of the meter key block: key types and the single state record.
// Assumes the register header is on the include path.
package mkx_pkg;
  // ==========================================
  // Key type digit codes
  typedef enum logic [1:0] {
    MKX_KEY_INIT   = 2'h0,  // Initial transfer key
    MKX_KEY_DEF    = 2'h1,  // Default transfer key
    MKX_KEY_UNIQUE = 2'h2,  // Unique transfer key
    MKX_KEY_COMMON = 2'h3   // Common transfer key
  } mkx_ktype_t;

  // ==========================================
  // Whole module state, registered as one word
  typedef struct packed {
    logic        aw_got;     // Write address held
    logic        w_got;      // Write data held
    logic [7:0]  awaddr;     // Held write address
    logic [31:0] wdata;      // Held write data
    logic [3:0]  wstrb;      // Held byte enables
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;       // Control word
    logic [31:0] kct;        // Pending key change fields
    logic [31:0] issuer;     // Issuer digits, right justified
    logic [31:0] mref_lo;    // Reference digits 7..0
    logic [31:0] mref_hi;    // Reference digits 12..8
    logic [31:0] supply;     // Supply group and tariff digits
    logic [24:0] token;      // Last token identifier and flag
    logic [3:0]  rev;        // Stored key revision number
    logic [7:0]  exp;        // Stored key expiry number
    mkx_ktype_t  ktype;      // Stored key type
    logic        reject;     // Last token rejected
    logic        checked;    // A token was checked
    logic        commit_err; // Last commit refused
  } mkx_state_t;
endpackage

// ### verif/mkx_vend_model.sv
// Vending side model: hands out key revisions and token identifiers.
// Assumes the bench steps it with advance and reads outputs a cycle later.
`timescale 1ns/10ps

module mkx_vend_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        advance,     // Move on to the next vending key
  input  wire logic  [7:0] key_exp,     // Expiry of the key in use
  input  wire logic  [7:0] want_top,    // Requested identifier top byte
  input  wire logic        force_stale, // Misbehave: issue with expired key
  output logic       [3:0] next_rev,    // Revision of the current key
  output logic      [23:0] token_id     // Identifier of the next token
);
  // ==========================================
  // Revision sequence
  logic [3:0] rev_ff;  // Current key revision
  // First key of a group is one; nine wraps back to one, zero never used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rev_ff <= 4'h1;
    end else if (advance) begin
      rev_ff <= (rev_ff == 4'h9) ? 4'h1 : rev_ff + 4'h1;
    end
  end
  assign next_rev = rev_ff;
  // ==========================================
  // Identifier issue
  // Clamped so an expired key is never used, unless told to misbehave
  assign token_id = {(want_top > key_exp && !force_stale) ? key_exp : want_top, 16'h3C5A};
endmodule

// ### verif/meter_key_revision_expiry_blocks_test.sv
// Self-checking bench for the meter key block, driven over its register bus.
// Assumes the register header and the package are compiled first.
`timescale 1ns/10ps
`include "mkx_regs.svh"

module meter_key_revision_expiry_blocks_test
  import mkx_pkg::*;
;
  // ==========================================
  // Wires and counters
  logic        aclk, aresetn, advance, force_stale;
  logic  [7:0] s_axi_awaddr, s_axi_araddr, key_expiry_number, want_top;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic  [3:0] s_axi_wstrb, key_revision_number, next_rev;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, token_reject;
  logic  [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] token_id;
  int          miscompares, compares, cyc;

  mkx_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .token_reject, .key_revision_number, .key_expiry_number);
  mkx_vend_model vend (.aclk, .aresetn, .advance, .key_exp(key_expiry_number), .want_top,
    .force_stale, .next_rev, .token_id);

  // ==========================================
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic close_out();
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic commit(input mkx_ktype_t k, input logic [3:0] v, input logic [7:0] x);
    logic [1:0] r;
    axi_wr(`MKX_OFS_KCT, {18'h0, k, x[3:0], x[7:4], v}, r);
    axi_wr(`MKX_OFS_CMD, 32'h1, r);
    cmp("commit bresp", 32'h0, {30'h0, r});
  endtask
  // Token from the vending model, then the design's verdict on it
  task automatic tok(input logic h, input logic [7:0] t, input logic f, input logic e);
    logic [1:0] r;
    @(posedge aclk);
    want_top <= t;
    force_stale <= f;
    @(posedge aclk);
    axi_wr(`MKX_OFS_TOKEN, {7'h0, h, token_id}, r);
    cmp("token_reject", {31'h0, e}, {31'h0, token_reject});
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    cmp("reset revision", 32'h0, {28'h0, key_revision_number});
    axi_rd(`MKX_OFS_STATUS, d, r);
    cmp("reset status", 32'h0, d & 32'h0007_FFFF);
    axi_rd(8'h40, d, r);
    cmp("unmapped rresp", 32'h2, {30'h0, r});
    axi_wr(8'h44, 32'hFFFF_FFFF, r);
    cmp("unmapped bresp", 32'h2, {30'h0, r});
  endtask
  task automatic t_revisions();
    logic [31:0] d;
    logic [1:0] r;
    // Ten key changes run the revision through its wrap
    for (int i = 0; i < 10; i++) begin
      commit(MKX_KEY_DEF, next_rev, 8'(8'h50 + i));
      cmp("revision", 32'((i % 9) + 1), {28'h0, key_revision_number});
      cmp("expiry", 32'h50 + i, {24'h0, key_expiry_number});
      @(posedge aclk);
      advance <= 1'b1;
      @(posedge aclk);
      advance <= 1'b0;
      @(posedge aclk);
    end
    // Out-of-range revisions leave the stored key alone
    for (int j = 0; j < 2; j++) begin
      commit(MKX_KEY_COMMON, j ? 4'hA : 4'h0, 8'h77);
      cmp("bad revision", 32'h1, {28'h0, key_revision_number});
      cmp("bad expiry", 32'h59, {24'h0, key_expiry_number});
      axi_rd(`MKX_OFS_STATUS, d, r);
      cmp("commit_err", 32'h1, {31'h0, d[18]});
    end
    axi_wr(`MKX_OFS_KCT, {18'h0, MKX_KEY_DEF, 8'h12, 4'h5}, r);
    cmp("uncommitted", 32'h1, {28'h0, key_revision_number});
    commit(MKX_KEY_INIT, 4'h7, 8'h33);
    cmp("initial revision", 32'h0, {28'h0, key_revision_number});
    cmp("initial expiry", 32'h0, {24'h0, key_expiry_number});
  endtask
  task automatic t_expiry();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(`MKX_OFS_CTRL, 32'h1, r);
    commit(MKX_KEY_UNIQUE, 4'h3, 8'h5A);
    tok(1'b1, 8'h5A, 1'b0, 1'b0);
    tok(1'b1, 8'h5B, 1'b0, 1'b0);
    tok(1'b1, 8'h5B, 1'b1, 1'b1);
    axi_rd(`MKX_OFS_STATUS, d, r);
    cmp("status reject", 32'h1, {31'h0, d[16]});
    tok(1'b0, 8'hFF, 1'b1, 1'b0);
    tok(1'b1, 8'hFF, 1'b1, 1'b1);
    tok(1'b1, 8'h00, 1'b1, 1'b0);
    axi_wr(`MKX_OFS_CTRL, 32'h0, r);
    tok(1'b1, 8'hFF, 1'b1, 1'b0);
    axi_wr(`MKX_OFS_CTRL, 32'h1, r);
    commit(MKX_KEY_INIT, 4'h0, 8'h00);
    tok(1'b1, 8'hFF, 1'b1, 1'b0);
  endtask
  task automatic blk(input logic [31:0] c, input mkx_ktype_t k, input logic [31:0] ah, input logic [31:0] al);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(`MKX_OFS_CTRL, c, r);
    axi_wr(`MKX_OFS_KCT, {18'h0, k, 8'h00, 4'h3}, r);
    axi_rd(`MKX_OFS_ACCT_HI, d, r);
    cmp("account hi", ah, d);
    axi_rd(`MKX_OFS_ACCT_LO, d, r);
    cmp("account lo", al, d);
    axi_rd(`MKX_OFS_CBLK_HI, d, r);
    cmp("control hi", {2'h0, k, 28'h1234560}, d);
    axi_rd(`MKX_OFS_CBLK_LO, d, r);
    cmp("control lo", 32'h73FF_FFFF, d);
  endtask
  task automatic t_blocks();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(`MKX_OFS_ISSUER, 32'h0003_1592, r);
    axi_wr(`MKX_OFS_MREF_LO, 32'h4567_8903, r);
    axi_wr(`MKX_OFS_MREF_HI, 32'h0000_0123, r);
    axi_wr(`MKX_OFS_SUPPLY, 32'h0712_3456, r);
    blk(32'h0, MKX_KEY_DEF, 32'h3159_2123, 32'h4567_8903);
    blk(32'h2, MKX_KEY_UNIQUE, 32'h5920_0123, 32'h4567_8903);
    blk(32'h0, MKX_KEY_COMMON, 32'h3159_2000, 32'h0);
    blk(32'h2, MKX_KEY_COMMON, 32'h5920_0000, 32'h0);
    axi_wr(`MKX_OFS_ISSUER, 32'h0003_159A, r);
    axi_rd(`MKX_OFS_STATUS, d, r);
    cmp("digit range", 32'h1, {31'h0, d[19]});
    cmp("control range", 32'h0, {31'h0, d[20]});
    // Pending default key with revision zero makes the control block illegal
    axi_wr(`MKX_OFS_KCT, {18'h0, MKX_KEY_DEF, 8'h00, 4'h0}, r);
    axi_rd(`MKX_OFS_STATUS, d, r);
    cmp("control range bad", 32'h1, {31'h0, d[20]});
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {aresetn, advance, force_stale, want_top, cyc, miscompares, compares} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_revisions();
    t_expiry();
    t_blocks();
    close_out();
  end
endmodule
